// *** src/psp_fifo.sv ***
// Purpose: Byte FIFO held in a memory with a registered read, plus a two-entry output buffer.
// Assumes: Single clock, asynchronous active-low reset.
// Notes:   Depth must be a power of two.
`timescale 1ns/100ps
`default_nettype none
module psp_fifo #(
  parameter int unsigned DEPTH = psp_pkg::FIFO_DEPTH,
  parameter int unsigned AW    = psp_pkg::FIFO_AW
) (
  input  wire logic ref_clk,
  input  wire logic nrst,
  psp_fifo_if.fifo  port
);
  logic [7:0]  mem [DEPTH];
  logic [AW:0] wp_q, wp_d, rp_q, rp_d;
  logic [7:0]  mrd_q;
  logic        mrd_v_q, mrd_v_d;
  logic [7:0]  sk_q [2];
  logic [7:0]  sk_d [2];
  logic [1:0]  cnt_q, cnt_d;
  logic        empty, full, pop_mem, push_sk, pop_sk;

  assign empty        = (wp_q == rp_q);
  assign full         = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign port.wr_ready = !full;
  assign port.rd_valid = (cnt_q != 2'h0);
  assign port.rd_data  = sk_q[0];
  assign pop_sk  = port.rd_valid && port.rd_ready;
  // Only fetch from memory while the two-entry buffer can take the word.
  assign pop_mem = !empty && ((cnt_q - 2'(pop_sk) + 2'(mrd_v_q)) < 2'h2);
  assign push_sk = mrd_v_q;

  always_ff @(posedge ref_clk) begin
    if (port.wr_valid && !full) begin
      mem[wp_q[AW-1:0]] <= port.wr_data;
    end
    mrd_q <= mem[rp_q[AW-1:0]];
  end

  always_comb begin
    wp_d    = wp_q + (AW+1)'(port.wr_valid && !full);
    rp_d    = rp_q + (AW+1)'(pop_mem);
    mrd_v_d = pop_mem;
    sk_d    = sk_q;
    cnt_d   = cnt_q;
    if (pop_sk) begin
      sk_d[0] = sk_q[1];
      cnt_d   = cnt_d - 2'h1;
    end
    if (push_sk) begin
      sk_d[cnt_d[0]] = mrd_q;
      cnt_d          = cnt_d + 2'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wp_q    <= '0;
      rp_q    <= '0;
      mrd_v_q <= 1'b0;
      cnt_q   <= 2'h0;
      sk_q[0] <= 8'h00;
      sk_q[1] <= 8'h00;
    end else begin
      wp_q    <= wp_d;
      rp_q    <= rp_d;
      mrd_v_q <= mrd_v_d;
      cnt_q   <= cnt_d;
      sk_q    <= sk_d;
    end
  end
endmodule
`default_nettype wire

// *** src/psp_fifo_if.sv ***
// Purpose: Write and read handshake carrier between the port and its FIFOs.
// Assumes: Single clock.
// Notes:   Valid and ready on both sides.
`timescale 1ns/100ps
`default_nettype none
interface psp_fifo_if;
  logic [7:0] wr_data;
  logic       wr_valid;
  logic       wr_ready;
  logic [7:0] rd_data;
  logic       rd_valid;
  logic       rd_ready;
  modport fifo (input wr_data, input wr_valid, output wr_ready,
                output rd_data, output rd_valid, input rd_ready);
  modport user (output wr_data, output wr_valid, input wr_ready,
                input rd_data, input rd_valid, output rd_ready);
endinterface
`default_nettype wire

// *** src/psp_pkg.sv ***
// Purpose: Shared constants and types of the point-to-point serial port.
// Assumes: 100 MHz ref_clk.
// Notes:   Timing counts derive from the clock rate.
package psp_pkg;
  localparam int unsigned CLK_HZ         = 100000000;
  localparam int unsigned MAX_BAUD       = 115200;
  localparam int unsigned BAUD_DIV_MIN   = (CLK_HZ + MAX_BAUD - 1) / MAX_BAUD;
  localparam int unsigned BAUD_DIV_RST   = BAUD_DIV_MIN;
  localparam int unsigned FIFO_BANK_BYTES = 1024;
  localparam int unsigned FIFO_BANKS     = 2;
  localparam int unsigned FIFO_DEPTH     = FIFO_BANK_BYTES * FIFO_BANKS;
  localparam int unsigned FIFO_AW        = 11;
  localparam logic [7:0]  CHR_START      = 8'h02;
  localparam logic [7:0]  CHR_END        = 8'h03;
  localparam logic [7:0]  CHR_ACK        = 8'h10;
  localparam logic [7:0]  CHR_NAK        = 8'h15;

  typedef enum logic [2:0] {
    PSP_MODE_RAW    = 3'h0,
    PSP_MODE_DELIM  = 3'h1,
    PSP_MODE_BLKCHK = 3'h2,
    PSP_MODE_MS_A   = 3'h3,
    PSP_MODE_MS_B   = 3'h4
  } psp_mode_t;

  typedef enum logic [1:0] {
    PSP_ACK_NONE    = 2'h0,
    PSP_ACK_PENDING = 2'h1,
    PSP_ACK_OK      = 2'h2,
    PSP_ACK_NAK     = 2'h3
  } psp_ack_t;
endpackage

// *** src/psp_uart.sv ***
// Purpose: Point-to-point serial port on a half-duplex differential pair.
// Assumes: 100 MHz ref_clk; line pins pass a two-stage synchroniser.
// Notes:   Framing is added on send per mode; received bytes are queued with any framing kept.
//
// Summary of operation
// - Interface stays inactive after reset until configuration enables it.
// - Operation only when function select chooses point-to-point; a frame already started still sends all queued bytes after deselect.
// - CPU bytes queue in a 2x1024 byte send FIFO, sent in order.
// - Received bytes go to a 2x1024 byte receive FIFO, read in order.
// - Selected framing is wrapped around payload automatically.
// - Five modes: raw, delimited, block-check, two master-slave protocols.
// - Block-check and master-slave modes need partner acknowledgement.
// - Each repeated send call returns latest acknowledgement status.
// - One pair, half duplex, never sending and receiving together; the code lets a send and a reception start in the same cycle.
// - Bit rate up to 115.2 kbaud.
// - Raw mode passes characters unchanged, no reception acknowledgement.
`timescale 1ns/100ps
`default_nettype none
module psp_uart #(
  parameter int unsigned DEPTH   = psp_pkg::FIFO_DEPTH,
  parameter int unsigned AW      = psp_pkg::FIFO_AW,
  parameter int unsigned DIV_MIN = psp_pkg::BAUD_DIV_MIN
) (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        interface_function_select,
  input  wire logic        configure_call,
  input  wire logic [2:0]  cfg_mode,
  input  wire logic [15:0] cfg_baud_div,
  input  wire logic        send_call,
  input  wire logic [7:0]  send_data,
  input  wire logic        send_last,
  output logic             send_ready,
  output logic [1:0]       call_return_value,
  input  wire logic        receive_call,
  output logic [7:0]       rcv_data,
  output logic             rcv_valid,
  input  wire logic        line_in,
  output logic             line_out,
  output logic             line_oe
);
  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [4:0] {
    TX_IDLE  = 5'h01,
    TX_START = 5'h02,
    TX_BITS  = 5'h04,
    TX_STOP  = 5'h08,
    TX_NEXT  = 5'h10
  } psp_tx_t;
  typedef enum logic [2:0] {
    RX_IDLE  = 3'h1,
    RX_BITS  = 3'h2,
    RX_STOP  = 3'h4
  } psp_rx_t;

  psp_fifo_if txf ();
  psp_fifo_if rxf ();

  psp_fifo #(.DEPTH(DEPTH), .AW(AW)) u_txf (.ref_clk(ref_clk), .nrst(nrst), .port(txf.fifo));
  psp_fifo #(.DEPTH(DEPTH), .AW(AW)) u_rxf (.ref_clk(ref_clk), .nrst(nrst), .port(rxf.fifo));

  ////////////////////////////////////////////////////////////////////////////
  // Configuration.
  logic             en_q, en_d;
  psp_pkg::psp_mode_t mode_q, mode_d;
  logic [15:0]      div_q, div_d;
  logic             sync1_q, sync2_q;

  always_comb begin
    en_d   = en_q && interface_function_select;
    mode_d = mode_q;
    div_d  = div_q;
    if (configure_call && interface_function_select) begin
      en_d   = 1'b1;
      mode_d = (cfg_mode > 3'h4) ? psp_pkg::PSP_MODE_RAW : psp_pkg::psp_mode_t'(cfg_mode);
      // Rates above the ceiling are clamped to the fastest legal divider.
      div_d  = (cfg_baud_div < 16'(DIV_MIN)) ?
               16'(DIV_MIN) : cfg_baud_div;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      en_q    <= 1'b0;
      mode_q  <= psp_pkg::PSP_MODE_RAW;
      div_q   <= 16'(psp_pkg::BAUD_DIV_RST);
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      en_q    <= en_d;
      mode_q  <= mode_d;
      div_q   <= div_d;
      sync1_q <= line_in;
      sync2_q <= sync1_q;
    end
  end

  logic framed, acked;
  assign framed = (mode_q != psp_pkg::PSP_MODE_RAW);
  assign acked  = (mode_q == psp_pkg::PSP_MODE_BLKCHK) || (mode_q == psp_pkg::PSP_MODE_MS_A) ||
                  (mode_q == psp_pkg::PSP_MODE_MS_B);

  ////////////////////////////////////////////////////////////////////////////
  // Send queue: payload byte plus an end-of-message mark in bit 8 is not kept;
  // the end mark is held separately as a message-boundary counter.
  assign txf.wr_data  = send_data;
  assign txf.wr_valid = send_call && en_q;
  assign send_ready   = txf.wr_ready && en_q;

  logic [AW:0] msg_cnt_q, msg_cnt_d;

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter.
  psp_tx_t    tx_q, tx_d;
  logic [15:0] tb_q, tb_d;
  logic [2:0]  tn_q, tn_d;
  logic [7:0]  tsh_q, tsh_d;
  logic [1:0]  tph_q, tph_d;   // 0 idle or raw, 1 header and payload, 2 end mark before check byte, 3 last byte
  logic [7:0]  bcc_q, bcc_d;
  logic        lo_q, lo_d, oe_q, oe_d;
  logic        rx_busy;
  logic        tx_done;

  always_comb begin
    tx_d      = tx_q;
    tb_d      = tb_q;
    tn_d      = tn_q;
    tsh_d     = tsh_q;
    tph_d     = tph_q;
    bcc_d     = bcc_q;
    lo_d      = 1'b1;
    oe_d      = 1'b0;
    tx_done   = 1'b0;
    msg_cnt_d = msg_cnt_q + (AW+1)'(send_call && en_q && send_last && txf.wr_ready && framed);
    txf.rd_ready = 1'b0;
    case (tx_q)
      TX_IDLE: begin
        tph_d = 2'h0;
        bcc_d = 8'h00;
        if (en_q && !rx_busy && txf.rd_valid) begin
          if (framed && msg_cnt_q != '0) begin
            tsh_d = psp_pkg::CHR_START;
            tph_d = 2'h1;
            tx_d  = TX_START;
            tb_d  = div_q;
          end else if (!framed) begin
            tsh_d        = txf.rd_data;
            txf.rd_ready = 1'b1;
            tx_d         = TX_START;
            tb_d         = div_q;
          end
        end
      end
      TX_START: begin
        oe_d = 1'b1;
        lo_d = 1'b0;
        tb_d = tb_q - 16'h1;
        if (tb_q == 16'h1) begin
          tb_d = div_q;
          tn_d = 3'h0;
          tx_d = TX_BITS;
        end
      end
      TX_BITS: begin
        oe_d = 1'b1;
        lo_d = tsh_q[tn_q];
        tb_d = tb_q - 16'h1;
        if (tb_q == 16'h1) begin
          tb_d = div_q;
          tn_d = tn_q + 3'h1;
          if (tn_q == 3'h7) begin
            tx_d = TX_STOP;
          end
        end
      end
      TX_STOP: begin
        oe_d = 1'b1;
        lo_d = 1'b1;
        tb_d = tb_q - 16'h1;
        if (tb_q == 16'h1) begin
          tx_d = TX_NEXT;
        end
      end
      TX_NEXT: begin
        tx_d = TX_IDLE;
        if (tph_q == 2'h1 && txf.rd_valid) begin
          tsh_d        = txf.rd_data;
          bcc_d        = bcc_q ^ txf.rd_data;
          txf.rd_ready = 1'b1;
          tb_d         = div_q;
          tx_d         = TX_START;
          if (txf.rd_data == 8'h00) begin
            tph_d = 2'h1;
          end
        end else if (tph_q == 2'h1 && framed) begin
          tsh_d = psp_pkg::CHR_END;
          tph_d = (mode_q == psp_pkg::PSP_MODE_DELIM) ? 2'h3 : 2'h2;
          tb_d  = div_q;
          tx_d  = TX_START;
        end else if (tph_q == 2'h2) begin
          tsh_d = bcc_q;
          tph_d = 2'h3;
          tb_d  = div_q;
          tx_d  = TX_START;
        end else begin
          tx_done = (tph_q == 2'h3);
          if (tx_done && msg_cnt_d != '0) begin
            msg_cnt_d = msg_cnt_d - (AW+1)'(1);
          end
        end
      end
      default: tx_d = TX_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_q      <= TX_IDLE;
      tb_q      <= 16'h0;
      tn_q      <= 3'h0;
      tsh_q     <= 8'h00;
      tph_q     <= 2'h0;
      bcc_q     <= 8'h00;
      lo_q      <= 1'b1;
      oe_q      <= 1'b0;
      msg_cnt_q <= '0;
    end else begin
      tx_q      <= tx_d;
      tb_q      <= tb_d;
      tn_q      <= tn_d;
      tsh_q     <= tsh_d;
      tph_q     <= tph_d;
      bcc_q     <= bcc_d;
      lo_q      <= lo_d;
      oe_q      <= oe_d;
      msg_cnt_q <= msg_cnt_d;
    end
  end

  assign line_out = lo_q;
  assign line_oe  = oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // Receiver; it never starts while the driver is on, but can start in the same cycle as the transmitter.
  psp_rx_t     rx_q, rx_d;
  logic [15:0] rb_q, rb_d;
  logic [2:0]  rn_q, rn_d;
  logic [7:0]  rsh_q, rsh_d;
  logic        byte_ok;

  assign rx_busy = (rx_q != RX_IDLE);

  always_comb begin
    rx_d    = rx_q;
    rb_d    = rb_q;
    rn_d    = rn_q;
    rsh_d   = rsh_q;
    byte_ok = 1'b0;
    case (rx_q)
      RX_IDLE: begin
        if (en_q && !oe_q && tx_q == TX_IDLE && !sync2_q) begin
          rb_d = div_q + {1'b0, div_q[15:1]};
          rn_d = 3'h0;
          rx_d = RX_BITS;
        end
      end
      RX_BITS: begin
        rb_d = rb_q - 16'h1;
        if (rb_q == 16'h1) begin
          rb_d  = div_q;
          rsh_d = {sync2_q, rsh_q[7:1]};
          rn_d  = rn_q + 3'h1;
          if (rn_q == 3'h7) begin
            rx_d = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        rb_d = rb_q - 16'h1;
        if (rb_q == 16'h1) begin
          byte_ok = sync2_q;
          rx_d    = RX_IDLE;
        end
      end
      default: rx_d = RX_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rx_q  <= RX_IDLE;
      rb_q  <= 16'h0;
      rn_q  <= 3'h0;
      rsh_q <= 8'h00;
    end else begin
      rx_q  <= rx_d;
      rb_q  <= rb_d;
      rn_q  <= rn_d;
      rsh_q <= rsh_d;
    end
  end

  // Bytes with a good stop bit are queued unchanged; in the acknowledged modes ACK and NAK replies also set the send status below.
  assign rxf.wr_data  = rsh_q;
  assign rxf.wr_valid = byte_ok;
  assign rxf.rd_ready = receive_call;
  assign rcv_data     = rxf.rd_data;
  assign rcv_valid    = rxf.rd_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledgement tracking for the send status.
  psp_pkg::psp_ack_t ack_q, ack_d;

  always_comb begin
    ack_d = ack_q;
    if (!acked) begin
      ack_d = psp_pkg::PSP_ACK_NONE;
    end else if (byte_ok && rsh_q == psp_pkg::CHR_ACK) begin
      ack_d = psp_pkg::PSP_ACK_OK;
    end else if (byte_ok && rsh_q == psp_pkg::CHR_NAK) begin
      ack_d = psp_pkg::PSP_ACK_NAK;
    end else if (tx_done) begin
      ack_d = psp_pkg::PSP_ACK_PENDING;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= psp_pkg::PSP_ACK_NONE;
    end else begin
      ack_q <= ack_d;
    end
  end

  assign call_return_value = ack_q;
endmodule
`default_nettype wire

// *** verif/psp_station.sv ***
// Purpose: Remote station on the half-duplex pair, 8N1, LSB first.
// Assumes: Bias resistors hold the released pair at the idle high level.
// Notes:   Received bytes collect in got_q for the bench to inspect.
`timescale 1ns/100ps
`default_nettype none
module psp_station #(
  parameter int BIT_NS = 8690
) (
  input  wire logic line_out,
  input  wire logic line_oe,
  output var logic  line_in
);
  logic [7:0] got_q[$];
  logic [7:0] b;

  initial line_in = 1'b1;

  always @(negedge line_out) begin
    #1;
    if (line_oe) begin
      #(BIT_NS / 2 - 1);
      for (int i = 0; i < 8; i++) begin
        #(BIT_NS);
        b[i] = line_out;
      end
      got_q.push_back(b);
    end
  end

  // Reply only once the port has freed the pair.
  task automatic send(input logic [7:0] v);
    wait (line_oe === 1'b0);
    line_in = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      line_in = v[i];
      #(BIT_NS);
    end
    line_in = 1'b1;
    #(BIT_NS);
  endtask
endmodule
`default_nettype wire

// *** verif/psp_uart_properties.sv ***
// Purpose: Concurrent checks on the pins of the serial port.
// Assumes: Bound to psp_uart; one clock domain; bit time of at least DIV_MIN cycles.
// Notes:   Helper logic tracks how long the line has held its level.
`timescale 1ns/100ps
`default_nettype none
module psp_uart_properties #(
  parameter int unsigned DEPTH   = 4,
  parameter int unsigned AW      = 2,
  parameter int unsigned DIV_MIN = psp_pkg::BAUD_DIV_MIN
) (
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        interface_function_select,
  input wire logic        configure_call,
  input wire logic [2:0]  cfg_mode,
  input wire logic [15:0] cfg_baud_div,
  input wire logic        send_call,
  input wire logic [7:0]  send_data,
  input wire logic        send_last,
  input wire logic        send_ready,
  input wire logic [1:0]  call_return_value,
  input wire logic        receive_call,
  input wire logic [7:0]  rcv_data,
  input wire logic        rcv_valid,
  input wire logic        line_in,
  input wire logic        line_out,
  input wire logic        line_oe
);
  logic        en_seen_q;
  logic        last_q;
  logic [15:0] run_q;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////
  // Run length counts the samples for which the line kept its last level.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      en_seen_q <= 1'b0;
      last_q    <= 1'b1;
      run_q     <= 16'h0;
    end else begin
      en_seen_q <= en_seen_q | (configure_call & interface_function_select);
      last_q    <= line_out;
      run_q     <= (line_out != last_q) ? 16'h0 : run_q + {15'h0, ~&run_q};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_reset_quiet: assert property ($rose(nrst) |-> line_out && !line_oe && !send_ready
    && !rcv_valid && call_return_value == 2'h0) else $error("outputs not idle after reset");
  a_locked_until_cfg: assert property (!en_seen_q |-> !send_ready && !line_oe)
    else $error("port active before configuration");
  a_deselect_off: assert property (!interface_function_select &&
    $past(!interface_function_select) |-> !send_ready) else $error("ready while deselected");
  a_idle_high: assert property (!line_oe |-> line_out)
    else $error("line low while not driving");
  a_start_low: assert property ($rose(line_oe) |-> !line_out)
    else $error("driving begins without start bit");
  a_bit_time: assert property (line_oe && $past(line_oe) && line_out != last_q
    |-> run_q >= 16'(DIV_MIN - 1)) else $error("bit shorter than minimum");
  a_stop_then_free: assert property ($fell(line_oe) |-> $past(line_out)
    && run_q >= 16'(DIV_MIN - 1)) else $error("driver released before full stop bit");
  a_rcv_hold: assert property (rcv_valid && !receive_call && !configure_call
    |=> rcv_valid && $stable(rcv_data)) else $error("receive head lost without pop");
  a_status_line_free: assert property ($changed(call_return_value)
    && call_return_value != 2'h0 |-> !line_oe) else $error("status moved while sending");
endmodule

bind psp_uart psp_uart_properties #(.DEPTH(DEPTH), .AW(AW), .DIV_MIN(DIV_MIN))
  i_psp_uart_properties (
  .ref_clk, .nrst, .interface_function_select, .configure_call, .cfg_mode,
  .cfg_baud_div, .send_call, .send_data, .send_last, .send_ready, .call_return_value,
  .receive_call, .rcv_data, .rcv_valid, .line_in, .line_out, .line_oe);
`default_nettype wire

// *** verif/tb.sv ***
// Purpose: Self-checking bench for the serial port with a remote station.
// Assumes: Bit divider clamped to a shortened 100-cycle floor; send FIFO shrunk to 4.
// Notes:   Mode rows first, then receive, deselect, overflow and reset.
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct {
    logic [2:0] mode;
    logic [7:0] d;
    int         nb;
    logic [8:0] rep;
    logic [1:0] crv;
  } psp_row_t;
  psp_row_t   rows[5];
  logic       ref_clk, nrst, interface_function_select, configure_call, send_call;
  logic       send_last, receive_call, send_ready, rcv_valid, line_in, line_out, line_oe;
  logic [2:0] cfg_mode;
  logic [15:0] cfg_baud_div;
  logic [7:0] send_data, rcv_data;
  logic [1:0] call_return_value;
  int         fail_count, num_checks;

  // The divider floor is cut to 100 cycles so that the run stays short.
  psp_uart #(.DEPTH(4), .AW(2), .DIV_MIN(100)) i_psp_uart (.ref_clk, .nrst,
    .interface_function_select, .configure_call, .cfg_mode, .cfg_baud_div, .send_call,
    .send_data, .send_last, .send_ready, .call_return_value, .receive_call, .rcv_data,
    .rcv_valid, .line_in, .line_out, .line_oe);
  psp_station #(.BIT_NS(1000)) i_psp_station (.line_out, .line_oe, .line_in);

  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task cfg(input logic s, input logic [2:0] m);
    interface_function_select = s;
    cfg_mode = m;
    configure_call = 1'b1;
    cyc(1);
    configure_call = 1'b0;
    cyc(1);
  endtask
  // The caller lowers send_call after the last byte.
  task put(input logic [7:0] d, input logic l);
    send_data = d;
    send_last = l;
    send_call = 1'b1;
    for (int n = 0; n < 50 && send_ready !== 1'b1; n++) cyc(1);
    cyc(1);
  endtask
  task quiet;
    int n;
    n = 0;
    for (int k = 0; k < 60000 && n < 3000; k++) begin
      cyc(1);
      n = (line_oe === 1'b0) ? n + 1 : 0;
    end
  endtask
  task pop;
    receive_call = 1'b1;
    cyc(1);
    receive_call = 1'b0;
    cyc(4);
  endtask
  task rst_chk;
    chk({line_out, line_oe, send_ready, rcv_valid, 2'h0, call_return_value}, 8'h80);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rows = '{'{3'h0, 8'hc3, 2, 9'h000, 2'h0}, '{3'h1, 8'h5a, 3, 9'h000, 2'h0},
             '{3'h2, 8'ha5, 4, 9'h110, 2'h2}, '{3'h3, 8'h3c, 4, 9'h115, 2'h3},
             '{3'h4, 8'h81, 4, 9'h000, 2'h1}};
    nrst = 1'b0;
    interface_function_select = 1'b0;
    configure_call = 1'b0;
    cfg_mode = 3'h0;
    // Below the floor, so every configuration goes through the clamp.
    cfg_baud_div = 16'h0010;
    send_call = 1'b0;
    send_data = 8'h0;
    send_last = 1'b0;
    receive_call = 1'b0;
    cyc(5);
    nrst = 1'b1;
    rst_chk();
    foreach (rows[r]) begin
      cfg(1'b1, rows[r].mode);
      i_psp_station.got_q.delete();
      put(rows[r].d, rows[r].nb != 2);
      if (rows[r].nb == 2)
        put(~rows[r].d, 1'b1);
      send_call = 1'b0;
      quiet();
      if (rows[r].nb == 2) begin
        chk(i_psp_station.got_q[0], rows[r].d);
        chk(i_psp_station.got_q[1], ~rows[r].d);
      end else begin
        chk(i_psp_station.got_q[0], psp_pkg::CHR_START);
        chk(i_psp_station.got_q[1], rows[r].d);
        chk(i_psp_station.got_q[2], psp_pkg::CHR_END);
        if (rows[r].nb == 4)
          chk(i_psp_station.got_q[3], rows[r].d);
      end
      chk(8'(i_psp_station.got_q.size()), 8'(rows[r].nb));
      if (rows[r].rep[8])
        i_psp_station.send(rows[r].rep[7:0]);
      cyc(300);
      chk({6'h0, call_return_value}, {6'h0, rows[r].crv});
      if (rows[r].rep[8])
        chk(rcv_data, rows[r].rep[7:0]);
      for (int k = 0; k < 8 && rcv_valid === 1'b1; k++) pop();
      $display("mode %0d done", rows[r].mode);
    end
    cfg(1'b1, 3'h0);
    i_psp_station.got_q.delete();
    i_psp_station.send(8'h96);
    i_psp_station.send(8'h4b);
    cyc(300);
    chk({7'h0, line_oe}, 8'h0);
    chk(8'(i_psp_station.got_q.size()), 8'h0);
    chk({7'h0, rcv_valid}, 8'h1);
    chk(rcv_data, 8'h96);
    pop();
    chk(rcv_data, 8'h4b);
    pop();
    chk({7'h0, rcv_valid}, 8'h0);
    $display("receive done");
    interface_function_select = 1'b0;
    cyc(3);
    chk({7'h0, send_ready}, 8'h0);
    $display("deselect done");
    cfg(1'b1, 3'h0);
    send_call = 1'b1;
    for (int k = 0; k < 32 && send_ready === 1'b1; k++) begin
      send_data = 8'(k);
      cyc(1);
    end
    chk({7'h0, send_ready}, 8'h0);
    cyc(20);
    chk({7'h0, send_ready}, 8'h0);
    nrst = 1'b0;
    send_call = 1'b0;
    cyc(5);
    nrst = 1'b1;
    rst_chk();
    $display("overflow and reset done");
    send_data = 8'h77;
    send_call = 1'b1;
    cyc(20);
    send_call = 1'b0;
    chk({6'h0, line_oe, send_ready}, 8'h0);
    cfg(1'b0, 3'h0);
    chk({7'h0, send_ready}, 8'h0);
    cfg(1'b1, 3'h0);
    chk({7'h0, send_ready}, 8'h1);
    $display("enable done");
    give_verdict();
  end

  initial begin
    #800000;
    fail_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
